// File: dv/high_side_switch_control_test.sv
`timescale 1ns/100ps
module high_side_switch_control_test;
  import hs_switch_pkg::*;
  localparam int OC_CYC = 8;
  localparam int OL_CYC = 16;
  localparam logic [11:0] MIX = {SRC_PWM2, SRC_PWM1, SRC_ON, SRC_OFF};
  logic mclk, nrst, ctrlWrite, dutyWriteA, dutyWriteB, freqWrite, cfgWrite, timer1, timer2;
  logic overvoltShutdownDisableIn, undervoltShutdownDisableIn, supplyFaultRecoveryIn;
  logic overvoltShutdownDisable, undervoltShutdownDisable, supplyFaultRecovery;
  logic supplyOvervolt, supplyUndervolt;
  chip_mode_t        chipMode;
  logic [11:0]       ctrlData, switchControl;
  logic [7:0]        dutyData, pwmDutyA, pwmDutyB, dA, dB;
  logic [1:0]        freqData, pwmFreqSelect;
  logic [3:0]        switchOutput, shortSel, openSel;
  logic [2:0]        cfgRead;
  fault_flags_t      flagClear, faultFlags;
  load_sense_t [3:0] loadSense;
  int                error_cnt, num_checks, hi;
  high_side_switch_control #(.OC_CYC(OC_CYC), .OL_CYC(OL_CYC), .PWM_LO(2), .PWM_HI(1)) dut_u (.*);
  load_model load_u (.*);
  assign cfgRead = {overvoltShutdownDisable, undervoltShutdownDisable, supplyFaultRecovery};
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  ////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // one strobe per write; kind picks ctrl, duty a, duty b, freq, cfg
  task automatic wr(input int kind, input logic [11:0] d);
    @(negedge mclk);
    {ctrlData, dutyData, freqData} = {d, d[7:0], d[1:0]};
    {overvoltShutdownDisableIn, undervoltShutdownDisableIn, supplyFaultRecoveryIn} = d[2:0];
    {ctrlWrite, dutyWriteA, dutyWriteB, freqWrite, cfgWrite} = 5'h10 >> kind;
    @(negedge mclk);
    {ctrlWrite, dutyWriteA, dutyWriteB, freqWrite, cfgWrite} = '0;
  endtask
  task automatic clr(input fault_flags_t m);
    @(negedge mclk);
    flagClear = m;
    @(negedge mclk);
    flagClear = '0;
  endtask
  // bounded wait: a flag that never comes ends the run
  task automatic wait_flag(input int idx);
    for (int n = 0; faultFlags[idx] !== 1'b1; n++) begin
      if (n > 50) begin
        error_cnt++;
        report_and_stop();
      end
      tick(1);
    end
  endtask
  task automatic measure(input int sw, input int cyc);
    hi = 0;
    repeat (cyc) begin
      tick(1);
      hi += int'(switchOutput[sw]);
    end
  endtask
  function automatic logic [11:0] rnd_ctrl();
    for (int g = 0; g < 4; g++) rnd_ctrl[3*g+:3] = 3'($urandom_range(7, 0));
  endfunction
  // expected switch states while both duties are zero; codes 6 and 7 act as off
  function automatic logic [15:0] exp_on(input logic [11:0] f);
    exp_on = '0;
    for (int g = 0; g < 4; g++)
      exp_on[g] = f[3*g+:3] == SRC_ON || (f[3*g+:3] == SRC_TIMER1 && timer1)
                  || (f[3*g+:3] == SRC_TIMER2 && timer2);
  endfunction
  // on-time of one full period: duty counts times the step length
  function automatic logic [15:0] pwm_on(input logic [7:0] d, input int step);
    return 16'(int'(d) * step);
  endfunction
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #900000;
    error_cnt++;
    report_and_stop();
  end
  ////////////////////////////////
  initial begin
    nrst = 1'b0;
    chipMode = MODE_NORMAL;
    {ctrlWrite, dutyWriteA, dutyWriteB, freqWrite, cfgWrite} = '0;
    {ctrlData, dutyData, freqData, flagClear, shortSel, openSel} = '0;
    {overvoltShutdownDisableIn, undervoltShutdownDisableIn, supplyFaultRecoveryIn} = '0;
    {timer1, timer2, supplyOvervolt, supplyUndervolt} = 4'h8;
    void'($urandom(32'h1bcca700));
    tick(16);
    nrst = 1'b1;
    // every source code on all four switches; timer 1 high, timer 2 low, duties zero
    for (int c = 0; c < 6; c++) begin
      wr(0, {4{c[2:0]}});
      check("switchControl", 16'({4{c[2:0]}}), 16'(switchControl));
      tick(1);
      check("switchOutput", (c == 1 || c == 2) ? 16'hf : 16'h0, 16'(switchOutput));
    end
    repeat (20) begin
      {timer1, timer2} = 2'($urandom);
      ctrlData = rnd_ctrl();
      wr(0, ctrlData);
      check("switchControl", 16'(ctrlData), 16'(switchControl));
      tick(1);
      check("switchOutput", exp_on(ctrlData), 16'(switchOutput));
    end
    // host keeps duty floors for reliable sensing
    dA = 8'($urandom_range(255, 4));
    dB = 8'($urandom_range(255, 2));
    wr(1, {4'h0, dA});
    wr(2, {4'h0, dB});
    wr(3, 12'h1);
    check("pwmDuty", {dB, dA}, {pwmDutyB, pwmDutyA});
    check("pwmFreqSelect", 16'h1, 16'(pwmFreqSelect));
    wr(0, MIX);
    measure(2, 256);
    check("pwmOnA", pwm_on(dA, 1), 16'(hi));
    chipMode = MODE_STOP;
    wr(0, rnd_ctrl());
    wr(2, 12'h0);
    check("lockedDuty", 16'(dB), 16'(pwmDutyB));
    check("lockedCtrl", 16'(MIX), 16'(switchControl));
    measure(3, 512);
    check("pwmOnB", pwm_on(dB, 2), 16'(hi));
    chipMode = MODE_SLEEP;
    wr(4, 12'h7);
    check("cfg", 16'h0, 16'(cfgRead));
    shortSel[1] = 1'b1;
    tick(OC_CYC - 1);
    check("ocEarly", 16'h0, 16'(faultFlags.overcurrent));
    wait_flag(5);
    check("switchControl", 16'(MIX & ~12'h038), 16'(switchControl));
    check("switchOutput1", 16'h0, 16'(switchOutput[1]));
    shortSel = '0;
    tick(5);
    check("ocSticky", 16'h2, 16'(faultFlags.overcurrent));
    chipMode = MODE_RESTART;
    tick(2);
    check("switchOutput", 16'h0, 16'(switchOutput));
    chipMode = MODE_NORMAL;
    clr('1);
    check("faultFlags", 16'h0, 16'(faultFlags));
    wr(0, 12'h249);
    tick(1);
    check("switchOutput", 16'hf, 16'(switchOutput));
    // open load with a one-cycle gap must not trip, steady open load must
    repeat (2) begin
      openSel[1] = 1'b1;
      tick(OL_CYC - 2);
      openSel[1] = 1'b0;
      tick(1);
    end
    check("olGap", 16'h0, 16'(faultFlags.openLoad));
    openSel[1] = 1'b1;
    wait_flag(1);
    check("switchOutput", 16'hf, 16'(switchOutput));
    openSel = '0;
    tick(3);
    check("olSticky", 16'h2, 16'(faultFlags.openLoad));
    clr(10'h002);
    check("faultFlags", 16'h0, 16'(faultFlags));
    // supply faults: recovery on, then recovery off, then shutdown disabled
    wr(4, 12'h1);
    check("cfg", 16'h1, 16'(cfgRead));
    supplyOvervolt = 1'b1;
    tick(2);
    check("ovOff", 16'h2000, {12'(faultFlags), switchOutput});
    supplyOvervolt = 1'b0;
    tick(2);
    check("switchOutput", 16'hf, 16'(switchOutput));
    clr('1);
    wr(4, 12'h0);
    supplyUndervolt = 1'b1;
    tick(2);
    check("uvOff", 16'h1000, {12'(faultFlags), switchOutput});
    supplyUndervolt = 1'b0;
    tick(1);
    check("uvHold", 16'h0, 16'(switchOutput));
    tick(1);
    check("noRecover", 16'h0, {switchControl, switchOutput});
    wr(4, 12'h6);
    wr(0, 12'h249);
    {supplyOvervolt, supplyUndervolt} = 2'h3;
    tick(2);
    check("supplyDisabled", 16'h300f, {12'(faultFlags), switchOutput});
    {supplyOvervolt, supplyUndervolt} = 2'h0;
    report_and_stop();
  end
endmodule // high_side_switch_control_test
bind high_side_switch_control hs_switch_check #(.OC_CYC(OC_CYC), .OL_CYC(OL_CYC)) chk_u (.*);

// File: dv/hs_switch_check_sva.sv
`timescale 1ns/100ps
module hs_switch_check
  import hs_switch_pkg::*;
#(
  parameter int OC_CYC = 8,
  parameter int OL_CYC = 16
) (
  input wire logic                         mclk,
  input wire logic                         nrst,
  input wire hs_switch_pkg::chip_mode_t    chipMode,
  input wire logic                         ctrlWrite,
  input wire logic [11:0]                  ctrlData,
  input wire logic                         supplyOvervolt,
  input wire logic                         supplyUndervolt,
  input wire logic                         overvoltShutdownDisable,
  input wire logic                         undervoltShutdownDisable,
  input wire logic                         supplyFaultRecovery,
  input wire hs_switch_pkg::fault_flags_t  flagClear,
  input wire hs_switch_pkg::load_sense_t [3:0] loadSense,
  input wire logic [3:0]                   switchOutput,
  input wire logic [11:0]                  switchControl,
  input wire hs_switch_pkg::fault_flags_t  faultFlags
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////
  // calm: no comparator active now or a cycle ago, so no hardware override is in flight
  logic senseQ, supQ, calm;
  int   ocRun, olRun;
  assign calm = loadSense == '0 && senseQ && !supplyOvervolt && !supplyUndervolt && !supQ;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      senseQ <= 1'b0;
      supQ   <= 1'b1;
    end else begin
      senseQ <= loadSense == '0;
      supQ   <= supplyOvervolt | supplyUndervolt;
    end
  end
  // run lengths of load faults on switch 1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ocRun <= 0;
      olRun <= 0;
    end else begin
      ocRun <= (loadSense[1].overCurrent && switchOutput[1]) ? ocRun + 1 : 0;
      olRun <= (loadSense[1].underCurrent && switchOutput[1]) ? olRun + 1 : 0;
    end
  end
  ////////////////////////////////
  a_write_taken: assert property (
    ctrlWrite && chipMode == MODE_NORMAL && calm |=> switchControl == $past(ctrlData))
    else $error("control write lost");
  a_mode_lock: assert property (
    chipMode inside {MODE_STOP, MODE_SLEEP} && calm |=> $stable(switchControl))
    else $error("control changed in low power");
  a_forced_off: assert property (
    chipMode inside {MODE_RESTART, MODE_FAILSAFE} |=> switchOutput == '0)
    else $error("output on in restart");
  a_ov_off: assert property (
    supplyOvervolt && !overvoltShutdownDisable |=> switchOutput == '0)
    else $error("output on at overvoltage");
  a_uv_off: assert property (
    supplyUndervolt && !undervoltShutdownDisable |=> switchOutput == '0)
    else $error("output on at undervoltage");
  a_supply_flag: assert property (
    supplyOvervolt |=> faultFlags.supplyOver)
    else $error("overvoltage flag missing");
  a_flags_sticky: assert property (
    loadSense == '0 && senseQ && flagClear == '0
      |=> $stable({faultFlags.overcurrent, faultFlags.openLoad}))
    else $error("load flag changed");
  a_oc_trip: assert property (
    ocRun == OC_CYC |-> ##[0:2]
      (!switchOutput[1] && faultFlags.overcurrent[1] && switchControl[5:3] == SRC_OFF))
    else $error("overcurrent trip missing");
  a_release_cleared: assert property (
    $fell(supplyOvervolt || supplyUndervolt) && !supplyFaultRecovery
      && !overvoltShutdownDisable && !undervoltShutdownDisable
      |=> switchOutput == '0 && switchControl == '0)
    else $error("output back after supply release without recovery");
  a_ol_flag: assert property (
    olRun == OL_CYC |-> ##[0:2] faultFlags.openLoad[1])
    else $error("open-load flag missing");
endmodule // hs_switch_check

// File: dv/load_model.sv
`timescale 1ns/100ps
module load_model
  import hs_switch_pkg::*;
(
  input  wire logic [3:0]                     switchOutput,
  input  wire logic [3:0]                     shortSel,
  input  wire logic [3:0]                     openSel,
  output hs_switch_pkg::load_sense_t [3:0]    loadSense
);
  // a dead switch carries no current, so both comparators stay low
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      loadSense[g].overCurrent  = switchOutput[g] & shortSel[g];
      loadSense[g].underCurrent = switchOutput[g] & openSel[g];
    end
  end
endmodule // load_model

// File: hdl/condition_filter.sv
`timescale 1ns/100ps
module condition_filter #(
  parameter int FILTER_CYC = 1600
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic active,
  output logic      fired
);
  localparam int CW = $clog2(FILTER_CYC + 1);
  logic [CW-1:0] count;

  // elaboration check: a zero filter time would never let the counter reach its end
  if (FILTER_CYC < 1) begin : gBadTime
    $error("filter time must be at least one cycle");
  end

  // count restarts whenever the condition drops; one-cycle fire at the full time
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      fired <= 1'b0;
    end else if (!active) begin
      count <= '0;
      fired <= 1'b0;
    end else if (count == CW'(FILTER_CYC - 1)) begin
      count <= '0;
      fired <= 1'b1;
    end else begin
      count <= count + CW'(1);
      fired <= 1'b0;
    end
  end
endmodule // condition_filter

// File: hdl/high_side_switch_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// - each output driven by direct control, a timer, or a pwm generator
// - configuration writable only in normal mode; held and locked in stop or sleep
// - restart or fail-safe mode forces all outputs off
// - supply over-voltage switches outputs off unless disabled by config bit
// - supply under-voltage switches outputs off unless disabled by separate bit
// - after supply fault clears with recovery set, outputs return to programmed state
// - after supply fault clears with recovery clear, outputs stay off, fields cleared
// - supply events set only their own supply flag
// - overcurrent lasting the filter time switches that output off
// - overcurrent shutdown sets its flag and resets the control field to off
// - overcurrent flags are cleared only by the host
// - open load checked while on; filtered, flagged, output stays on
// - open-load flags stay set until the host clears them
// - protection and pwm/timer control stay active in stop and sleep
// - outputs off in restart/fail-safe; fields are kept, outputs resume when the mode ends
// - two pwm generators with independent 8-bit duty registers
// - each generator selects 200 Hz or 400 Hz independently
// - host programs duty and frequency before assignment; sharing allowed
// - pwm output starts at once when a field selects a generator
module high_side_switch_control
  import hs_switch_pkg::*;
#(
  parameter int NSW      = NUM_SWITCH,
  parameter int OC_CYC   = OC_FILTER_CYC,
  parameter int OL_CYC   = OL_FILTER_CYC,
  parameter int PWM_LO   = PWM_STEP_LO_CYC,
  parameter int PWM_HI   = PWM_STEP_HI_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire hs_switch_pkg::chip_mode_t    chipMode,
  input  wire logic                         ctrlWrite,
  input  wire logic [NUM_SWITCH*3-1:0]      ctrlData,
  input  wire logic                         dutyWriteA,
  input  wire logic                         dutyWriteB,
  input  wire logic [DUTY_W-1:0]            dutyData,
  input  wire logic                         freqWrite,
  input  wire logic [NUM_PWM-1:0]           freqData,
  input  wire logic                         cfgWrite,
  input  wire logic                         overvoltShutdownDisableIn,
  input  wire logic                         undervoltShutdownDisableIn,
  input  wire logic                         supplyFaultRecoveryIn,
  input  wire hs_switch_pkg::fault_flags_t  flagClear,
  input  wire logic                         timer1,
  input  wire logic                         timer2,
  input  wire logic                         supplyOvervolt,
  input  wire logic                         supplyUndervolt,
  input  wire hs_switch_pkg::load_sense_t [NUM_SWITCH-1:0] loadSense,
  output logic [NUM_SWITCH-1:0]             switchOutput,
  output logic [NUM_SWITCH*3-1:0]           switchControl,
  output logic [DUTY_W-1:0]                 pwmDutyA,
  output logic [DUTY_W-1:0]                 pwmDutyB,
  output logic [NUM_PWM-1:0]                pwmFreqSelect,
  output logic                              overvoltShutdownDisable,
  output logic                              undervoltShutdownDisable,
  output logic                              supplyFaultRecovery,
  output hs_switch_pkg::fault_flags_t       faultFlags
);
  import hs_switch_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks: the port widths follow the package switch count
  if (NSW != NUM_SWITCH) begin : gBadCount
    $error("switch count must match the package");
  end

  // filters need at least one cycle of qualification
  if (OC_CYC < 1 || OL_CYC < 1) begin : gBadFilter
    $error("filter times must be at least one cycle");
  end

  // the low frequency needs the longer prescaler step
  if (PWM_HI < 1 || PWM_LO < PWM_HI) begin : gBadStep
    $error("pwm step counts unusable");
  end

  logic                  cfgOpen;
  logic                  forcedOff;
  logic                  ovShut;
  logic                  uvShut;
  logic                  supplyShut;
  logic                  supplyShutQ;
  logic                  supplyRelease;
  logic                  dropFields;
  logic [NUM_PWM-1:0]    pwmWave;
  logic [NUM_SWITCH-1:0] ocFire;
  logic [NUM_SWITCH-1:0] olFire;
  logic [NUM_SWITCH-1:0] wantOn;
  logic [NUM_SWITCH-1:0] next_out;

  ////////////////////////////////////////////////////////////////////////
  // mode gating
  assign cfgOpen   = (chipMode == MODE_NORMAL);
  assign forcedOff = (chipMode == MODE_RESTART) || (chipMode == MODE_FAILSAFE);

  // supply shutdown only while its disable bit is clear
  assign ovShut        = supplyOvervolt && !overvoltShutdownDisable;
  assign uvShut        = supplyUndervolt && !undervoltShutdownDisable;
  assign supplyShut    = ovShut || uvShut;
  assign supplyRelease = supplyShutQ && !supplyShut;
  // release without recovery: fields clear, and the switch must not blink back on meanwhile
  assign dropFields    = supplyRelease && !supplyFaultRecovery;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) supplyShutQ <= 1'b0;
    else supplyShutQ <= supplyShut;
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers, locked outside normal mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      overvoltShutdownDisable  <= 1'b0;
      undervoltShutdownDisable <= 1'b0;
      supplyFaultRecovery      <= 1'b0;
    end else if (cfgWrite && cfgOpen) begin
      overvoltShutdownDisable  <= overvoltShutdownDisableIn;
      undervoltShutdownDisable <= undervoltShutdownDisableIn;
      supplyFaultRecovery      <= supplyFaultRecoveryIn;
    end
  end

  // independent duty and frequency per generator
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwmDutyA      <= '0;
      pwmDutyB      <= '0;
      pwmFreqSelect <= '0;
    end else if (cfgOpen) begin
      if (dutyWriteA) pwmDutyA <= dutyData;
      if (dutyWriteB) pwmDutyB <= dutyData;
      if (freqWrite) pwmFreqSelect <= freqData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm generators
  pwm_channel #(.STEP_LO(PWM_LO), .STEP_HI(PWM_HI)) pwmA (
    .mclk     (mclk),
    .nrst     (nrst),
    .duty     (pwmDutyA),
    .freqHigh (pwmFreqSelect[0]),
    .pwmOut   (pwmWave[0])
  );

  pwm_channel #(.STEP_LO(PWM_LO), .STEP_HI(PWM_HI)) pwmB (
    .mclk     (mclk),
    .nrst     (nrst),
    .duty     (pwmDutyB),
    .freqHigh (pwmFreqSelect[1]),
    .pwmOut   (pwmWave[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // per-switch source select, filters and control fields
  genvar g;
  generate
    for (g = 0; g < NUM_SWITCH; g++) begin : gSw
      logic [2:0] field;
      assign field = switchControl[g*3 +: 3];

      // decode of the control field; unused codes act as off
      always_comb begin
        case (switch_src_t'(field))
          SRC_OFF:    wantOn[g] = 1'b0;
          SRC_ON:     wantOn[g] = 1'b1;
          SRC_TIMER1: wantOn[g] = timer1;
          SRC_TIMER2: wantOn[g] = timer2;
          SRC_PWM1:   wantOn[g] = pwmWave[0];
          SRC_PWM2:   wantOn[g] = pwmWave[1];
          default:    wantOn[g] = 1'b0;
        endcase
      end

      // protection stays active in every mode that lets the switch run
      assign next_out[g] = wantOn[g] && !forcedOff && !supplyShut && !dropFields
                           && !ocFire[g];

      // overcurrent filter watches only while the switch conducts
      condition_filter #(.FILTER_CYC(OC_CYC)) ocFilt (
        .mclk   (mclk),
        .nrst   (nrst),
        .active (switchOutput[g] && loadSense[g].overCurrent),
        .fired  (ocFire[g])
      );

      // open-load filter only in on-state
      condition_filter #(.FILTER_CYC(OL_CYC)) olFilt (
        .mclk   (mclk),
        .nrst   (nrst),
        .active (switchOutput[g] && loadSense[g].underCurrent),
        .fired  (olFire[g])
      );

      // field priority: overcurrent and a supply release without recovery override a host write
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          switchControl[g*3 +: 3] <= CTRL_RESET;
        end else if (ocFire[g]) begin
          switchControl[g*3 +: 3] <= SRC_OFF;
        end else if (dropFields) begin
          switchControl[g*3 +: 3] <= SRC_OFF;
        end else if (ctrlWrite && cfgOpen) begin
          switchControl[g*3 +: 3] <= ctrlData[g*3 +: 3];
        end
      end

      // sticky flags: hardware set beats host clear, never auto-cleared
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          faultFlags.overcurrent[g] <= 1'b0;
          faultFlags.openLoad[g]    <= 1'b0;
        end else begin
          if (ocFire[g]) faultFlags.overcurrent[g] <= 1'b1;
          else if (flagClear.overcurrent[g]) faultFlags.overcurrent[g] <= 1'b0;
          if (olFire[g]) faultFlags.openLoad[g] <= 1'b1;
          else if (flagClear.openLoad[g]) faultFlags.openLoad[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // output stage registered; release with recovery set resumes the field
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) switchOutput <= '0;
    else switchOutput <= next_out;
  end

  // supply flags set from the raw comparators, nothing else touched
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      faultFlags.supplyOver  <= 1'b0;
      faultFlags.supplyUnder <= 1'b0;
    end else begin
      if (supplyOvervolt) faultFlags.supplyOver <= 1'b1;
      else if (flagClear.supplyOver) faultFlags.supplyOver <= 1'b0;
      if (supplyUndervolt) faultFlags.supplyUnder <= 1'b1;
      else if (flagClear.supplyUnder) faultFlags.supplyUnder <= 1'b0;
    end
  end
endmodule // high_side_switch_control

// File: hdl/pwm_channel.sv
`timescale 1ns/100ps
module pwm_channel
  import hs_switch_pkg::*;
#(
  parameter int STEP_LO = PWM_STEP_LO_CYC,
  parameter int STEP_HI = PWM_STEP_HI_CYC
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [DUTY_W-1:0] duty,
  input  wire logic              freqHigh,
  output logic                   pwmOut
);
  localparam int PW = $clog2(STEP_LO + 1);
  logic [PW-1:0]     prescale;
  logic [DUTY_W-1:0] phase;
  logic              stepDone;

  // elaboration check: the prescaler is sized for the low frequency, the longer step
  if (STEP_HI < 1 || STEP_LO < STEP_HI) begin : gBadStep
    $error("pwm step counts unusable");
  end

  assign stepDone = freqHigh ? (prescale >= PW'(STEP_HI - 1)) : (prescale >= PW'(STEP_LO - 1));

  // prescaler gives 256 steps per period at the chosen frequency
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) prescale <= '0;
    else if (stepDone) prescale <= '0;
    else prescale <= prescale + PW'(1);
  end

  // free-running phase counter, never reset by host writes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) phase <= '0;
    else if (stepDone) phase <= phase + DUTY_W'(1);
  end

  // on while the phase is below the duty value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pwmOut <= 1'b0;
    else pwmOut <= (phase < duty);
  end
endmodule // pwm_channel

// File: include/hs_switch_pkg.sv
package hs_switch_pkg;

  // mclk period in ns (100 MHz)
  localparam int CLK_PERIOD_NS = 10;

  // filter times in microseconds
  localparam int OC_FILTER_US = 16;
  localparam int OL_FILTER_US = 64;
  localparam int OC_FILTER_CYC = (OC_FILTER_US * 1000) / CLK_PERIOD_NS;
  localparam int OL_FILTER_CYC = (OL_FILTER_US * 1000) / CLK_PERIOD_NS;

  // pwm base frequencies in Hz
  localparam int PWM_FREQ_LO_HZ = 200;
  localparam int PWM_FREQ_HI_HZ = 400;
  localparam int PWM_STEP_LO_CYC = (1000000000 / CLK_PERIOD_NS) / (PWM_FREQ_LO_HZ * 256);
  localparam int PWM_STEP_HI_CYC = (1000000000 / CLK_PERIOD_NS) / (PWM_FREQ_HI_HZ * 256);

  localparam int NUM_SWITCH = 4;
  localparam int NUM_PWM = 2;
  localparam int DUTY_W = 8;

  // per-switch control field encoding
  typedef enum logic [2:0] {
    SRC_OFF    = 3'h0,
    SRC_ON     = 3'h1,
    SRC_TIMER1 = 3'h2,
    SRC_TIMER2 = 3'h3,
    SRC_PWM1   = 3'h4,
    SRC_PWM2   = 3'h5
  } switch_src_t;

  localparam logic [2:0] CTRL_RESET = 3'h0;

  // chip operating modes
  typedef enum logic [4:0] {
    MODE_NORMAL   = 5'h01,
    MODE_STOP     = 5'h02,
    MODE_SLEEP    = 5'h04,
    MODE_RESTART  = 5'h08,
    MODE_FAILSAFE = 5'h10
  } chip_mode_t;

  // sticky fault flags gathered together
  typedef struct packed {
    logic                  supplyOver;
    logic                  supplyUnder;
    logic [NUM_SWITCH-1:0] overcurrent;
    logic [NUM_SWITCH-1:0] openLoad;
  } fault_flags_t;

  // per-switch analog comparator inputs
  typedef struct packed {
    logic overCurrent;
    logic underCurrent;
  } load_sense_t;

endpackage
